// >>> common/aux_seq_pkg.sv
// Purpose: shared constants and types for the auxiliary sequencer slot 11
// Assumes: 16-bit registers, 8-bit register addresses
// Notes:   field positions, reset values and routing codes for the design files live here
`default_nettype none
package aux_seq_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  SLOT11_CFG_ADDR  = 8'h9B;
    localparam logic [15:0] SLOT11_CFG_RESET = 16'h000B;
    localparam logic [15:0] READ_ZERO        = 16'h0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ENABLE_BIT = 15;
    localparam int GAIN_MSB   = 14;
    localparam int GAIN_LSB   = 13;
    localparam int NEG_BIT    = 4;
    localparam int POS_MSB    = 3;
    localparam int POS_LSB    = 0;

    // ------------------------------------------------------------------
    // field reset values
    // ------------------------------------------------------------------
    localparam logic       ENABLE_RESET = 1'h0;
    localparam logic [1:0] GAIN_RESET   = 2'h0;
    localparam logic       NEG_RESET    = 1'h0;
    localparam logic [3:0] POS_RESET    = 4'hB;

    // ------------------------------------------------------------------
    // codes
    // ------------------------------------------------------------------
    localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [2:0] GAIN_X1      = 3'h1;
    localparam logic [2:0] GAIN_X2      = 3'h2;
    localparam logic [2:0] GAIN_X4      = 3'h4;
    localparam logic [3:0] POS_LAST_EXTERNAL = 4'h7;

    typedef enum logic [2:0] {
        NEG_GROUND = 3'h1,
        NEG_EXT7   = 3'h2,
        NEG_AUTO   = 3'h4
    } neg_route_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       enable;
        logic [1:0] gain_code;
        logic       neg_select;
        logic [3:0] pos_select;
    } slot_cfg_t;

    typedef struct packed {
        logic       enable;
        logic [2:0] gain;
        logic [3:0] pos_select;
        logic       internal_node;
        neg_route_t neg_route;
    } slot_route_t;

endpackage
`default_nettype wire

// >>> logic/slot_route_decode.sv
// Purpose: turns the stored slot fields into converter routing controls
// Assumes: purely combinational; the caller registers the result
// Notes:   gain codes 10 and 11 both mean gain 4
`timescale 1ns/1ps
`default_nettype none
module slot_route_decode (
    input  wire aux_seq_pkg::slot_cfg_t   cfg,
    output aux_seq_pkg::slot_route_t      route
);

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] gain_of(input logic [1:0] code);
        unique case (code)
            aux_seq_pkg::GAIN_CODE_X1: gain_of = aux_seq_pkg::GAIN_X1;
            aux_seq_pkg::GAIN_CODE_X2: gain_of = aux_seq_pkg::GAIN_X2;
            default:                   gain_of = aux_seq_pkg::GAIN_X4;
        endcase
    endfunction

    function automatic logic is_internal(input logic [3:0] pos);
        is_internal = (pos > aux_seq_pkg::POS_LAST_EXTERNAL);
    endfunction

    always_comb begin
        route.enable        = cfg.enable;
        route.gain          = gain_of(cfg.gain_code);
        route.pos_select    = cfg.pos_select;
        route.internal_node = is_internal(cfg.pos_select);
        if (is_internal(cfg.pos_select)) begin
            // the converter picks its own reference for internal nodes
            route.neg_route = aux_seq_pkg::NEG_AUTO;
        end else if (cfg.neg_select) begin
            route.neg_route = aux_seq_pkg::NEG_EXT7;
        end else begin
            route.neg_route = aux_seq_pkg::NEG_GROUND;
        end
    end

endmodule
`default_nettype wire

// >>> logic/aux_adc_seq_step_cfg.sv
// Purpose: sequencer slot 11 configuration register and its routing outputs
// Assumes: requests come from the serial register decoder on ref_clk
// Notes:   reads answer one cycle after the request
//
// Notes on behaviour
// - register at 9Bh, 16 bits, resets 000Bh
// - bit 15 includes slot in sequence
// - bits 14:13 gain: 1, 2, 4, 4
// - bit 4 negative: ground or input seven
// - bits 3:0 codes 0-7 pick external inputs
// - codes 8-15 internal, negative chosen automatically
`timescale 1ns/1ps
`default_nettype none
module aux_adc_seq_step_cfg #(
    parameter int ADDR_W = 8
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire aux_seq_pkg::reg_req_t    req,
    output var  logic [15:0]              rd_data,
    output var  logic                     rd_valid,
    output var  aux_seq_pkg::slot_route_t route
);

    generate
        if (ADDR_W != 8) begin : g_bad_width
            $error("aux_adc_seq_step_cfg: ADDR_W must be 8");
        end
    endgenerate

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_int_n;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end
    assign rst_int_n = rst_sync_reg[1];

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        aux_seq_pkg::slot_cfg_t   cfg;
        logic [15:0]              rd_data;
        logic                     rd_valid;
        aux_seq_pkg::slot_route_t route;
    } state_t;

    localparam aux_seq_pkg::slot_cfg_t CFG_RESET = '{
        enable:     aux_seq_pkg::ENABLE_RESET,
        gain_code:  aux_seq_pkg::GAIN_RESET,
        neg_select: aux_seq_pkg::NEG_RESET,
        pos_select: aux_seq_pkg::POS_RESET
    };

    // routing view of the reset value, so outputs are consistent at once
    localparam aux_seq_pkg::slot_route_t ROUTE_RESET = '{
        enable:        aux_seq_pkg::ENABLE_RESET,
        gain:          aux_seq_pkg::GAIN_X1,
        pos_select:    aux_seq_pkg::POS_RESET,
        internal_node: 1'h1,
        neg_route:     aux_seq_pkg::NEG_AUTO
    };

    localparam state_t STATE_RESET = '{
        cfg:      CFG_RESET,
        rd_data:  aux_seq_pkg::READ_ZERO,
        rd_valid: 1'h0,
        route:    ROUTE_RESET
    };

    state_t                   state_reg;
    state_t                   state_next;
    aux_seq_pkg::slot_route_t route_dec;

    // ------------------------------------------------------------------
    // register image and field packing
    // ------------------------------------------------------------------
    function automatic logic [15:0] image_of(
        input aux_seq_pkg::slot_cfg_t c
    );
        logic [15:0] v;
        v = aux_seq_pkg::READ_ZERO;
        v[aux_seq_pkg::ENABLE_BIT] = c.enable;
        v[aux_seq_pkg::GAIN_MSB:aux_seq_pkg::GAIN_LSB] = c.gain_code;
        v[aux_seq_pkg::NEG_BIT] = c.neg_select;
        v[aux_seq_pkg::POS_MSB:aux_seq_pkg::POS_LSB] = c.pos_select;
        image_of = v;
    endfunction

    function automatic aux_seq_pkg::slot_cfg_t fields_of(
        input logic [15:0] w
    );
        // reserved bits 12:5 are simply never picked up
        fields_of.enable     = w[aux_seq_pkg::ENABLE_BIT];
        fields_of.gain_code  =
            w[aux_seq_pkg::GAIN_MSB:aux_seq_pkg::GAIN_LSB];
        fields_of.neg_select = w[aux_seq_pkg::NEG_BIT];
        fields_of.pos_select =
            w[aux_seq_pkg::POS_MSB:aux_seq_pkg::POS_LSB];
    endfunction

    // ------------------------------------------------------------------
    // routing decode of the stored fields
    // ------------------------------------------------------------------
    slot_route_decode u_decode (
        .cfg   (state_reg.cfg),
        .route (route_dec)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic hit;
        hit = (req.addr == aux_seq_pkg::SLOT11_CFG_ADDR);
        state_next = state_reg;
        state_next.rd_valid = req.rd;
        if (req.rd) begin
            // a read in the cycle of a write returns the old value
            state_next.rd_data = hit ? image_of(state_reg.cfg)
                                     : aux_seq_pkg::READ_ZERO;
        end
        if (req.wr && hit) begin
            state_next.cfg = fields_of(req.wdata);
        end
        // outputs follow the stored fields one cycle later
        state_next.route = route_dec;
    end

    always_ff @(posedge ref_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data  = state_reg.rd_data;
    assign rd_valid = state_reg.rd_valid;
    assign route    = state_reg.route;

endmodule
`default_nettype wire

// >>> verif/aux_slot_chk_sva.sv
// Purpose: port assertions for the slot 11 configuration register
// Assumes: one clock; reset is synchronised inside the block
// Notes:   route lags a mapped write by two edges
`timescale 1ns/1ps
`default_nettype none
module aux_slot_chk (
    input wire logic                     ref_clk,
    input wire logic                     rst_n,
    input wire aux_seq_pkg::reg_req_t    req,
    input wire logic [15:0]              rd_data,
    input wire logic                     rd_valid,
    input wire aux_seq_pkg::slot_route_t route
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // a lone write, so the route two edges on belongs to it alone
    sequence wr_one;
        req.wr && req.addr == 8'h9B ##1 !(req.wr && req.addr == 8'h9B);
    endsequence
    rd_answer_a: assert property (req.rd |=> rd_valid)
        else $error("read not answered");
    no_spurious_a: assert property (!req.rd |=> !rd_valid)
        else $error("answer without read");
    unmapped_zero_a: assert property
        (req.rd && req.addr != 8'h9B |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    reserved_zero_a: assert property
        (rd_valid |-> rd_data[12:5] == 8'h00)
        else $error("reserved bits not zero");
    reset_route_a: assert property
        ($rose(rst_n) |-> route.pos_select == 4'hB && !route.enable)
        else $error("route not at reset value");
    enable_follow_a: assert property
        (wr_one |=> route.enable == $past(req.wdata[15], 2))
        else $error("enable not from write");
    gain_map_a: assert property (wr_one |=> route.gain ==
        ($past(req.wdata[14], 2) ? 3'h4 :
         $past(req.wdata[13], 2) ? 3'h2 : 3'h1))
        else $error("gain wrong");
    // the data of the write itself decides, two edges back
    neg_pick_a: assert property (wr_one |=> route.neg_route ==
        ($past(req.wdata[3], 2) ? 3'h4 :
         $past(req.wdata[4], 2) ? 3'h2 : 3'h1))
        else $error("negative input wrong");
    pos_follow_a: assert property
        (wr_one |=> route.pos_select == $past(req.wdata[3:0], 2))
        else $error("positive select not from write");
    internal_auto_a: assert property (route.internal_node ==
        route.pos_select[3] && (route.internal_node == route.neg_route[2]))
        else $error("internal routing wrong");
endmodule
bind aux_adc_seq_step_cfg aux_slot_chk chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .route(route));
`default_nettype wire

// >>> verif/aux_adc_seq_step_cfg_tb.sv
// Purpose: self-checking bench for the slot 11 configuration register
// Assumes: inputs change at the falling edge
// Notes:   expected route is built here from the field meanings
`timescale 1ns/1ps
`default_nettype none
module aux_adc_seq_step_cfg_tb;
    logic                     ref_clk = 1'h0;
    logic                     rst_n = 1'h0;
    aux_seq_pkg::reg_req_t    req = '0;
    logic [15:0]              rd_data;
    logic                     rd_valid;
    aux_seq_pkg::slot_route_t route;
    logic [15:0]              prev;
    logic [15:0]              w;
    int                       n_errors = 0;
    int                       n_checks = 0;
    always #10 ref_clk = ~ref_clk;
    aux_adc_seq_step_cfg dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
        .rd_data(rd_data), .rd_valid(rd_valid), .route(route));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] route_of(input logic [15:0] v);
        logic [2:0] g;
        logic [2:0] n;
        g = v[14] ? 3'h4 : (v[13] ? 3'h2 : 3'h1);
        n = v[3] ? 3'h4 : (v[4] ? 3'h2 : 3'h1);
        return {4'h0, v[15], g, v[3:0], v[3], n};
    endfunction
    task automatic cyc(input logic wr, input logic rd, input logic [7:0] a,
                       input logic [15:0] d);
        @(negedge ref_clk);
        req.wr = wr;
        req.rd = rd;
        req.addr = a;
        req.wdata = d;
        @(negedge ref_clk);
        req.wr = 1'h0;
        req.rd = 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        cyc(1'h0, 1'h1, a, 16'h0000);
        check({15'h0000, rd_valid}, 16'h0001);
        check(rd_data, exp);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        @(negedge ref_clk);
        rst_n = 1'h0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'h1;
        repeat (4) @(negedge ref_clk);
        check(16'(route), route_of(16'h000B));
        rd_chk(8'h9B, 16'h000B);
    endtask
    // write and read together: the read must see the older image
    task automatic t_fields;
        prev = 16'h000B;
        for (int i = 0; i < 16; i++) begin
            w = {i[0], i[2:1], 8'hFF, i[0] ^ i[1], 4'(i)};
            cyc(1'h1, 1'h1, 8'h9B, w);
            check(rd_data, prev);
            @(negedge ref_clk);
            check(16'(route), route_of(w));
            prev = w & 16'hE01F;
        end
        rd_chk(8'h9B, prev);
    endtask
    task automatic t_unmapped;
        cyc(1'h1, 1'h0, 8'h9C, 16'hFFFF);
        rd_chk(8'h9C, 16'h0000);
        rd_chk(8'h9B, prev);
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        t_reset();
        t_fields();
        t_unmapped();
        t_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
